/* hw/serial_audio_output_port.sv */
/*
  Serial audio output port: bit clock, word select, four data lanes and
  a master clock, with an APB register slave.
  Assumes frames and link state come from logic on ref_clk_i.
*/
`timescale 1ns/1ps
`include "audio_out_defines.svh"

module serial_audio_output_port
  import audio_out_pkg::*;
#(
  parameter int PCLK_HZ = 25000000
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire audio_frame_t frame_i,
  input wire logic frame_valid_i,
  output logic frame_ready_o,
  input wire link_cfg_t link_cfg_i,
  output logic audio_bclk_o,
  output logic audio_lr_select_o,
  output logic [3:0] audio_data_o,
  output logic audio_mclk_o
);

  localparam int HMIN_P = (`AO_REF_HZ + PCLK_HZ - 1) / PCLK_HZ;
  localparam logic [3:0] HALF_LO = 4'((HMIN_P > `AO_HALF_MIN_MAX) ?
    HMIN_P : `AO_HALF_MIN_MAX);
  localparam logic [3:0] HALF_HI = 4'(`AO_HALF_MAX);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [3:0] div_ff;
  logic pll_dis_ff;
  logic [3:0] mclk_reg_ff;
  logic under_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  wire setup = psel_i & ~penable_i & ~pready_ff;
  wire wr_hit = psel_i & penable_i & pready_ff & pwrite_i;
  wire sel_ctrl = paddr_i == `AO_ADDR_CTRL;
  wire sel_div = paddr_i == `AO_ADDR_DIV;
  wire sel_stat = paddr_i == `AO_ADDR_STAT;
  wire sel_pll = paddr_i == `AO_ADDR_PLL;
  wire sel_mclk = paddr_i == `AO_ADDR_MCLK;
  wire mapped = sel_ctrl | sel_div | sel_stat | sel_pll | sel_mclk;

  // ----------------------------------------------------------------
  // Transport and lane selection
  // ----------------------------------------------------------------
  wire en = ctrl_ff[`AO_CTRL_EN];
  wire auto_dis = ctrl_ff[`AO_CTRL_AUTO_DIS];
  wire eff_frame = auto_dis ? ctrl_ff[`AO_CTRL_FRAME] :
    link_cfg_i.frame_mode;
  wire [3:0] legacy_mask = link_cfg_i.vid18 ? 4'h3 : 4'h1;
  wire [3:0] island_mask = ctrl_ff[`AO_CTRL_SURR] ? 4'hf : 4'h1;
  wire [3:0] nxt_mask = eff_frame ? 4'h1 :
    (link_cfg_i.legacy ? legacy_mask : island_mask);
  wire [1:0] wsz = ctrl_ff[`AO_CTRL_WSZ_LO +: 2];
  wire [5:0] word_bits = (wsz == 2'h0) ? 6'd16 :
    ((wsz == 2'h1) ? 6'd24 : 6'd32);

  // ----------------------------------------------------------------
  // Master clock ratio decode
  // ----------------------------------------------------------------
  wire [1:0] band = ctrl_ff[`AO_CTRL_BAND_LO +: 2];
  wire [2:0] dsel = mclk_reg_ff[2:0];
  wire [2:0] doff = dsel - {1'b0, band};
  wire top_x4 = (band == 2'h3) && (dsel == 3'h6);
  wire mclk_ovr = mclk_reg_ff[3];
  mclk_ratio_t sel_ratio;
  mclk_ratio_t ratio;
  always_comb begin
    case (doff)
      3'h0: sel_ratio = MR_X1;
      3'h1: sel_ratio = MR_X2;
      3'h2: sel_ratio = MR_X4;
      default: sel_ratio = top_x4 ? MR_X4 : MR_X2;
    endcase
  end
  always_comb begin
    if (pll_dis_ff) begin
      ratio = MR_OFF;
    end else if (!mclk_ovr) begin
      ratio = MR_X2;
    end else begin
      ratio = sel_ratio;
    end
  end

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [3:0] hcnt_ff;
  logic [3:0] mcnt_ff;
  logic bclk_ff;
  logic mclk_ff;
  wire [3:0] half = (div_ff < HALF_LO) ? HALF_LO :
    ((div_ff > HALF_HI) ? HALF_HI : div_ff);
  wire end_half = hcnt_ff >= half - 4'h1;
  wire [3:0] mh_raw = (ratio == MR_X4) ? (half >> 2) :
    ((ratio == MR_X2) ? (half >> 1) : half);
  wire [3:0] mhalf = (mh_raw == 4'h0) ? 4'h1 : mh_raw;
  wire mend = end_half | (mcnt_ff >= mhalf - 4'h1);
  wire fall = en & end_half & bclk_ff;
  wire [3:0] nxt_hcnt = (end_half | ~en) ? 4'h0 : hcnt_ff + 4'h1;
  wire [3:0] nxt_mcnt = (mend | ~en) ? 4'h0 : mcnt_ff + 4'h1;
  wire nxt_mclk = (~en | (ratio == MR_OFF)) ? 1'b0 :
    (mend ? ~mclk_ff : mclk_ff);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hcnt_ff <= 4'h0;
      mcnt_ff <= 4'h0;
      bclk_ff <= 1'b0;
      mclk_ff <= 1'b0;
    end else begin
      hcnt_ff <= nxt_hcnt;
      mcnt_ff <= nxt_mcnt;
      bclk_ff <= en & (end_half ? ~bclk_ff : bclk_ff);
      mclk_ff <= nxt_mclk;
    end
  end

  // ----------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------
  logic [5:0] bit_ff;
  logic ws_ff;
  logic [3:0] mask_ff;
  logic frame_ready_ff;
  wire ws_edge = fall & (bit_ff >= word_bits - 6'd1);
  wire take_frame = ws_edge & ws_ff;
  wire [5:0] nxt_bit = (~en | ws_edge) ? 6'h0 :
    (fall ? bit_ff + 6'd1 : bit_ff);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bit_ff <= 6'h0;
      ws_ff <= 1'b0;
      mask_ff <= 4'h0;
      frame_ready_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
      ws_ff <= en & (ws_edge ? ~ws_ff : ws_ff);
      mask_ff <= nxt_mask;
      frame_ready_ff <= take_frame & frame_valid_i;
    end
  end

  // ----------------------------------------------------------------
  // Per-lane shifters, retimed on the reference clock
  // ----------------------------------------------------------------
  logic [3:0] data_ff;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [31:0] sh_ff;
      logic [31:0] right_ff;
      logic out_ff;
      wire [31:0] new_left = frame_valid_i ? frame_i.left[g] : 32'h0;
      wire [31:0] nxt_right = frame_valid_i ? frame_i.right[g] : 32'h0;
      wire [31:0] nxt_word = ws_ff ? new_left : right_ff;
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          sh_ff <= 32'h0;
          right_ff <= 32'h0;
          out_ff <= 1'b0;
        end else begin
          if (take_frame) begin
            right_ff <= nxt_right;
          end
          if (fall) begin
            sh_ff <= ws_edge ? nxt_word : {sh_ff[30:0], 1'b0};
          end
          if (!en || !mask_ff[g]) begin
            out_ff <= 1'b0;
          end else if (fall) begin
            out_ff <= sh_ff[31];
          end
        end
      end
      assign data_ff[g] = out_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_ff} :
    sel_div ? {28'h0, div_ff} :
    sel_stat ? {24'h0, ratio, under_ff, mask_ff, eff_frame} :
    sel_pll ? {24'h0, pll_dis_ff, 7'h0} :
    sel_mclk ? {24'h0, mclk_reg_ff, 4'h0} : 32'h0;
  wire under_set = take_frame & ~frame_valid_i;
  wire under_clr = wr_hit & sel_stat & pwdata_i[`AO_STAT_UNDER];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_ff <= `AO_CTRL_RST;
      div_ff <= `AO_DIV_RST;
      pll_dis_ff <= `AO_PLL_RST;
      mclk_reg_ff <= `AO_MCLK_RST;
      under_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff <= setup ? rd_mux : 32'h0;
      under_ff <= under_set | (under_ff & ~under_clr);
      if (wr_hit & sel_ctrl) begin
        ctrl_ff <= pwdata_i[7:0];
      end
      if (wr_hit & sel_div) begin
        div_ff <= pwdata_i[3:0];
      end
      if (wr_hit & sel_pll) begin
        pll_dis_ff <= pwdata_i[`AO_PLL_DIS];
      end
      if (wr_hit & sel_mclk) begin
        mclk_reg_ff[3] <= pwdata_i[`AO_MCLK_OVR];
        if (mclk_reg_ff[3]) begin
          mclk_reg_ff[2:0] <= pwdata_i[`AO_MCLK_SEL_LO +: 3];
        end
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign frame_ready_o = frame_ready_ff;
  assign audio_bclk_o = bclk_ff;
  assign audio_lr_select_o = ws_ff;
  assign audio_data_o = data_ff;
  assign audio_mclk_o = mclk_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] since_ff;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !en || $changed(half)) begin
      since_ff <= 4'hf;
    end else if ($changed(bclk_ff)) begin
      since_ff <= 4'h0;
    end else if (since_ff != 4'hf) begin
      since_ff <= since_ff + 4'h1;
    end
  end

  property p_half_range;
    @(posedge ref_clk_i) disable iff (srst_i)
      half >= HALF_LO && half <= HALF_HI;
  endproperty
  a_half_range: assert property (p_half_range)
    else $error("bit clock half period outside range");

  property p_bclk_half;
    @(posedge ref_clk_i) disable iff (srst_i)
      $changed(bclk_ff) && $stable(half) && since_ff != 4'hf |->
      since_ff == half - 4'h1;
  endproperty
  a_bclk_half: assert property (p_bclk_half)
    else $error("bit clock half period wrong");

  property p_frame_lane;
    @(posedge ref_clk_i) disable iff (srst_i)
      eff_frame |=> mask_ff == 4'h1;
  endproperty
  a_frame_lane: assert property (p_frame_lane)
    else $error("frame transport drives extra lanes");

  property p_surround;
    @(posedge ref_clk_i) disable iff (srst_i)
      mask_ff == 4'hf |-> !$past(eff_frame);
  endproperty
  a_surround: assert property (p_surround)
    else $error("surround lanes in frame transport");

  property p_legacy;
    @(posedge ref_clk_i) disable iff (srst_i)
      link_cfg_i.legacy && !eff_frame |=>
      mask_ff == ($past(link_cfg_i.vid18) ? 4'h3 : 4'h1);
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy lane set wrong");

  property p_auto;
    @(posedge ref_clk_i) disable iff (srst_i)
      !auto_dis |-> eff_frame == link_cfg_i.frame_mode;
  endproperty
  a_auto: assert property (p_auto)
    else $error("transport not taken from link");

  sequence s_pll_off;
    pll_dis_ff ##1 pll_dis_ff;
  endsequence
  property p_mclk_off;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_pll_off |-> !mclk_ff;
  endproperty
  a_mclk_off: assert property (p_mclk_off)
    else $error("master clock runs with cleaning stage off");

  property p_mclk_default;
    @(posedge ref_clk_i) disable iff (srst_i)
      !mclk_ovr && !pll_dis_ff |-> ratio == MR_X2;
  endproperty
  a_mclk_default: assert property (p_mclk_default)
    else $error("default master clock ratio not x2");

  property p_ws_fall;
    @(posedge ref_clk_i) disable iff (srst_i)
      $changed(ws_ff) && en |-> $fell(bclk_ff);
  endproperty
  a_ws_fall: assert property (p_ws_fall)
    else $error("word select moved off falling edge");

  property p_lane_quiet;
    @(posedge ref_clk_i) disable iff (srst_i)
      !mask_ff[3] ##1 !mask_ff[3] |-> !data_ff[3];
  endproperty
  a_lane_quiet: assert property (p_lane_quiet)
    else $error("disabled lane carries data");

endmodule : serial_audio_output_port

/* hw/audio_out_defines.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  serial audio output port.
  Assumes a 25 MHz reference clock and a 12-bit APB byte address.
*/
`ifndef AUDIO_OUT_DEFINES_SVH
`define AUDIO_OUT_DEFINES_SVH

// ----------------------------------------------------------------
// Register word indices and byte addresses
// ----------------------------------------------------------------
`define AO_IDX_PLL 12'h02b
`define AO_IDX_MCLK 12'h03a
`define AO_ADDR_CTRL 12'h000
`define AO_ADDR_DIV 12'h004
`define AO_ADDR_STAT 12'h008
`define AO_ADDR_PLL (`AO_IDX_PLL * 12'h004)
`define AO_ADDR_MCLK (`AO_IDX_MCLK * 12'h004)

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AO_CTRL_EN 0
`define AO_CTRL_AUTO_DIS 1
`define AO_CTRL_FRAME 2
`define AO_CTRL_SURR 3
`define AO_CTRL_WSZ_LO 4
`define AO_CTRL_BAND_LO 6
`define AO_PLL_DIS 7
`define AO_MCLK_OVR 7
`define AO_MCLK_SEL_LO 4
`define AO_STAT_UNDER 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AO_CTRL_RST 8'h29
`define AO_DIV_RST 4'h4
`define AO_PLL_RST 1'b0
`define AO_MCLK_RST 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AO_REF_HZ 25000000
`define AO_BCLK_MIN_HZ 1000000
`define AO_BCLK_MAX_HZ 13000000
`define AO_HALF_MIN_MAX ((`AO_REF_HZ + 2*`AO_BCLK_MAX_HZ - 1) / \
  (2*`AO_BCLK_MAX_HZ))
`define AO_HALF_MAX (`AO_REF_HZ / (2*`AO_BCLK_MIN_HZ))

`endif

/* hw/audio_out_pkg.sv */
/*
  Types of the serial audio output port.
  Assumes the defines header for all numeric constants.
*/
package audio_out_pkg;

  // Master clock ratio actually in use
  typedef enum logic [1:0] {
    MR_X1 = 2'b00,
    MR_X2 = 2'b01,
    MR_X4 = 2'b11,
    MR_OFF = 2'b10
  } mclk_ratio_t;

  // One audio frame: left and right word for each of four lanes,
  // words left aligned, lane 0 is data output A
  typedef struct packed {
    logic [3:0][31:0] left;
    logic [3:0][31:0] right;
  } audio_frame_t;

  // Transport state reported by the link
  typedef struct packed {
    logic frame_mode;
    logic legacy;
    logic vid18;
  } link_cfg_t;

endpackage : audio_out_pkg

/* tb/audio_rx_model.sv */
/*
  Receiving codec model: deserializes the four audio data lanes.
  Assumes bit clock, word select and lanes from the port under test.
*/
`timescale 1ns/1ps
module audio_rx_model (
  input wire logic bclk_i,
  input wire logic lr_i,
  input wire logic [3:0] data_i,
  output logic [3:0][31:0] left_o,
  output logic [3:0][31:0] right_o,
  output logic [5:0] nbits_o,
  output int frames_o
);
  logic [3:0][31:0] sr;
  logic lr_q;
  logic [5:0] cnt;

  initial begin
    sr = '0;
    lr_q = 1'b0;
    cnt = '0;
    frames_o = 0;
    left_o = '0;
    right_o = '0;
    nbits_o = '0;
  end

  // Rising bit clock: MSB first, LSB lands as word select flips
  always @(posedge bclk_i) begin
    for (int l = 0; l < 4; l++) begin
      sr[l] = {sr[l][30:0], data_i[l]};
    end
    cnt = cnt + 6'h01;
    if (lr_i !== lr_q) begin
      if (lr_q) begin
        right_o <= sr;
        frames_o <= frames_o + 1;
      end else begin
        left_o <= sr;
      end
      nbits_o <= cnt;
      sr = '0;
      cnt = '0;
    end
    lr_q = lr_i;
  end
endmodule : audio_rx_model

/* tb/testbench.sv */
/*
  Self-checking bench of the serial audio output port.
  Assumes the design package, defines header and the codec model.
*/
`timescale 1ns/1ps
`include "audio_out_defines.svh"
module testbench;
  import audio_out_pkg::*;
  logic ref_clk_i, srst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic pready_o, pslverr_o, frame_valid_i, frame_ready_o, e;
  audio_frame_t frame_i;
  link_cfg_t link_cfg_i;
  logic audio_bclk_o, audio_lr_select_o, audio_mclk_o;
  logic [3:0] audio_data_o;
  logic [3:0][31:0] rx_l, rx_r;
  logic [5:0] rx_bits;
  int rx_frames, bad_count, n_compared, bclk_n, mclk_n, d, rdy_n;
  logic [7:0] t_ctrl [9] = '{8'h29, 8'h29, 8'h29, 8'h29, 8'h21, 8'h2b,
    8'h2f, 8'h19, 8'h09};
  logic [2:0] t_link [9] = '{3'h0, 3'h4, 3'h2, 3'h3, 3'h0, 3'h4, 3'h0,
    3'h0, 3'h0};
  logic [4:0] t_stat [9] = '{5'h1e, 5'h03, 5'h02, 5'h06, 5'h02, 5'h1e,
    5'h03, 5'h1e, 5'h1e};
  int t_bits [9] = '{32, 32, 32, 32, 32, 32, 32, 24, 16};
  int h_w [3] = '{1, 4, 15};
  int h_e [3] = '{1, 4, 12};
  int m_band [6] = '{0, 0, 0, 0, 1, 3};
  int m_code [6] = '{0, 1, 2, 3, 1, 6};
  logic [1:0] m_stat [6] = '{2'b00, 2'b01, 2'b11, 2'b01, 2'b00, 2'b11};
  int m_mul [6] = '{1, 2, 4, 2, 1, 4};

  serial_audio_output_port u_serial_audio_output_port (.ref_clk_i,
    .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .frame_i, .frame_valid_i,
    .frame_ready_o, .link_cfg_i, .audio_bclk_o, .audio_lr_select_o,
    .audio_data_o, .audio_mclk_o);

  audio_rx_model u_audio_rx_model (.bclk_i(audio_bclk_o),
    .lr_i(audio_lr_select_o), .data_i(audio_data_o), .left_o(rx_l),
    .right_o(rx_r), .nbits_o(rx_bits), .frames_o(rx_frames));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge audio_bclk_o) bclk_n++;
  always @(posedge audio_mclk_o) mclk_n++;
  always @(posedge ref_clk_i) if (frame_ready_o === 1'b1) rdy_n++;

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) bad_count++;
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rd

  task measure(input int c);
    bclk_n = 0;
    mclk_n = 0;
    repeat (c) @(posedge ref_clk_i);
  endtask : measure

  task wait_frames(input int k);
    int s;
    s = rx_frames;
    for (int n = 0; n < 6000 && rx_frames < s + k; n++) begin
      @(posedge ref_clk_i);
    end
    if (rx_frames < s + k) bad_count++;
  endtask : wait_frames

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    bad_count++;
    report_and_stop;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {srst_i, psel_i, penable_i, pwrite_i} = 4'h8;
    paddr_i = '0;
    pwdata_i = '0;
    frame_valid_i = 1'b1;
    link_cfg_i = '0;
    for (int l = 0; l < 4; l++) begin
      frame_i.left[l] = 32'h8421_c3a5 + 32'h1357_1111 * l;
      frame_i.right[l] = ~frame_i.left[l];
    end
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(`AO_ADDR_CTRL, 32'h29, '1);
    rd(`AO_ADDR_DIV, 32'h4, '1);
    rd(`AO_ADDR_PLL, 32'h0, '1);
    rd(`AO_ADDR_MCLK, 32'h0, '1);
    rd(`AO_ADDR_STAT, 32'h40, 32'hc0);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(e), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(`AO_ADDR_DIV, h_w[i]);
      measure(480);
      d = bclk_n - 240 / h_e[i];
      chk(32'(d * d <= 1), 32'h1);
    end
    wr(`AO_ADDR_DIV, 32'h4);
    $display("test bit clock done");
    for (int i = 0; i < 9; i++) begin
      link_cfg_i <= t_link[i];
      wr(`AO_ADDR_CTRL, 32'(t_ctrl[i]));
      d = rdy_n - rx_frames;
      wait_frames(3);
      d = rdy_n - rx_frames - d;
      chk(32'(d * d <= 1), 32'h1);
      rd(`AO_ADDR_STAT, 32'(t_stat[i]), 32'h1f);
      chk(32'(rx_bits), t_bits[i]);
      for (int l = 0; l < 4; l++) begin
        chk(rx_l[l], t_stat[i][l+1] ? frame_i.left[l] >> (32 - t_bits[i])
          : 0);
        chk(rx_r[l], t_stat[i][l+1] ? frame_i.right[l] >> (32 - t_bits[i])
          : 0);
      end
    end
    link_cfg_i <= '0;
    $display("test lanes done");
    wr(`AO_ADDR_CTRL, 32'h29);
    wr(`AO_ADDR_MCLK, 32'ha0);
    rd(`AO_ADDR_MCLK, 32'h80, 32'hf0);
    rd(`AO_ADDR_STAT, 32'h00, 32'hc0);
    for (int j = 0; j < 6; j++) begin
      wr(`AO_ADDR_CTRL, 32'h29 | (m_band[j] << 6));
      wr(`AO_ADDR_MCLK, 32'h80 | (m_code[j] << 4));
      rd(`AO_ADDR_STAT, 32'({m_stat[j], 6'h0}), 32'hc0);
      measure(400);
      d = mclk_n - m_mul[j] * bclk_n;
      chk(32'(d * d <= 4), 32'h1);
    end
    wr(`AO_ADDR_PLL, 32'h80);
    rd(`AO_ADDR_STAT, 32'h80, 32'hc0);
    measure(400);
    chk(mclk_n, 0);
    wr(`AO_ADDR_PLL, 32'h0);
    wr(`AO_ADDR_CTRL, 32'h28);
    @(posedge ref_clk_i);
    measure(400);
    chk(bclk_n + mclk_n, 0);
    chk(32'({audio_lr_select_o, audio_data_o}), 32'h0);
    wr(`AO_ADDR_CTRL, 32'h29);
    $display("test master clock done");
    frame_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    d = rdy_n;
    wait_frames(2);
    chk(rdy_n - d, 0);
    rd(`AO_ADDR_STAT, 32'h20, 32'h20);
    frame_valid_i <= 1'b1;
    wr(`AO_ADDR_STAT, 32'h20);
    rd(`AO_ADDR_STAT, 32'h00, 32'h20);
    $display("test underrun done");
    report_and_stop;
  end
endmodule : testbench
